/* verilog/dts_track_seq.sv */
// track write and read sequencer of the disk tester with its AXI4-Lite register slave
`timescale 1ns/10ps
`include "dts_defs.svh"
// Function
// - a track write starts at one index and ends at the next index
// - pattern words go out only 630 us after the index leading edge
// - with a seek, the track operation waits until the seek finishes
// - load strobe in upper mode puts six switch bits into pattern high half
// - load strobe in lower mode puts six switch bits into pattern low half
// - each pattern half shows on its own indicator outputs
// - single mode does one operation per start actuation
// - read/write-only skips seeking and uses the present track and selected head
// - repeat mode starts the next operation as soon as one ends, until start is turned off
// - sequential forward write starts at the present track, then steps upward by the switch value with chosen head
// - sequential forward read starts at the present track and head, stepping upward by the switch value
// - a return-to-zero step clears the head number
// - past the last cylinder the sweep returns to cylinder 000 and continues
// - a sweep step is taken as at most 255 tracks
module dts_track_seq
   import dts_pkg::*;
#(
   parameter int unsigned PAT_DLY_CYC =
      (`DTS_PAT_DLY_US * 1000 + `DTS_CLK_PERIOD_NS - 1) / `DTS_CLK_PERIOD_NS
)(
   input  wire logic        ref_clk_i,             // tester clock, 50 MHz
   input  wire logic        rst_n_i,               // async reset, active low
   input  wire logic [7:0]  s_axi_awaddr_i,        // write address
   input  wire logic        s_axi_awvalid_i,       // write address valid
   output logic             s_axi_awready_o,       // write address ready
   input  wire logic [31:0] s_axi_wdata_i,         // write data
   input  wire logic [3:0]  s_axi_wstrb_i,         // write byte enables
   input  wire logic        s_axi_wvalid_i,        // write data valid
   output logic             s_axi_wready_o,        // write data ready
   output logic [1:0]       s_axi_bresp_o,         // write response
   output logic             s_axi_bvalid_o,        // write response valid
   input  wire logic        s_axi_bready_i,        // write response ready
   input  wire logic [7:0]  s_axi_araddr_i,        // read address
   input  wire logic        s_axi_arvalid_i,       // read address valid
   output logic             s_axi_arready_o,       // read address ready
   output logic [31:0]      s_axi_rdata_o,         // read data
   output logic [1:0]       s_axi_rresp_o,         // read response
   output logic             s_axi_rvalid_o,        // read data valid
   input  wire logic        s_axi_rready_i,        // read data ready
   input  wire logic        index_i,               // drive index pulse, async
   input  wire logic        seek_done_i,           // drive seek complete, async
   output logic             seek_req_o,            // seek request level
   output logic [8:0]       seek_cyl_o,            // seek target cylinder
   output logic             return_to_zero_seek_o, // return-to-zero request level
   output logic [4:0]       head_sel_o,            // selected head
   output logic             write_gate_o,          // write gate to drive
   output logic             read_gate_o,           // read gate to drive
   output logic [11:0]      wr_data_o,             // pattern word to write channel
   output logic             wr_data_valid_o,       // pattern word valid
   input  wire logic        wr_data_ready_i,       // write channel takes word
   output logic [5:0]       upper_pattern_o,       // upper pattern indicators
   output logic [5:0]       lower_pattern_o        // lower pattern indicators
);
   dts_seq_s   q;
   dts_seq_s   d;
   logic       idx_rise;
   logic       done_rise;
   logic       wr_hs;
   logic       rd_hs;
   logic       push;
   logic       start_on;
   logic       go_step;
   logic       load_hs;
   logic       rtz_hs;
   logic [7:0] waddr;
   logic [7:0] raddr;
   dts_mode_e  mode;
   dts_op_e    op;
   logic [9:0] next_cyl;
   logic [8:0] target;

   function automatic logic [31:0] wmerge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = dat[i*8 +: 8];
         end
      end
      return r;
   endfunction

   assign s_axi_awready_o       = q.awready;
   assign s_axi_wready_o        = q.wready;
   assign s_axi_bvalid_o        = q.bvalid;
   assign s_axi_bresp_o         = q.bresp;
   assign s_axi_arready_o       = q.arready;
   assign s_axi_rvalid_o        = q.rvalid;
   assign s_axi_rdata_o         = q.rdata;
   assign s_axi_rresp_o         = q.rresp;
   assign seek_req_o            = q.seek_req;
   assign seek_cyl_o            = q.seek_cyl;
   assign return_to_zero_seek_o = q.rtz_req;
   assign head_sel_o            = q.head;
   assign write_gate_o          = q.wgate;
   assign read_gate_o           = q.rgate;
   assign upper_pattern_o       = q.pattern[11:6];
   assign lower_pattern_o       = q.pattern[5:0];

   // only the second and third sync stages are ever looked at
   assign idx_rise  = q.idx_sync[1] & ~q.idx_sync[2];
   assign done_rise = q.done_sync[1] & ~q.done_sync[2];
   assign wr_hs     = q.awready & s_axi_awvalid_i & s_axi_wvalid_i;
   assign rd_hs     = q.arready & s_axi_arvalid_i;
   assign waddr     = {s_axi_awaddr_i[7:2], 2'b00};
   assign raddr     = {s_axi_araddr_i[7:2], 2'b00};
   assign load_hs   = wr_hs & (waddr == `DTS_ADDR_LOAD);
   assign rtz_hs    = wr_hs & (waddr == `DTS_ADDR_RTZ);
   assign mode      = dts_mode_e'(q.ctrl[`DTS_CTRL_MODE_LSB +: 3]);
   assign op        = dts_op_e'(q.ctrl[`DTS_CTRL_OP_LSB +: 2]);
   assign start_on  = q.ctrl[`DTS_CTRL_START];
   // pattern is constant over a track, so a stalled channel loses nothing
   assign push      = (q.state == ST_XFER) & q.wgate & (32'(q.dly_cnt) >= PAT_DLY_CYC);
   assign go_step   = ((q.state == ST_IDLE) & q.pending)
                    | ((q.state == ST_DONE) & q.ctrl[`DTS_CTRL_REPEAT] & start_on);
   // only the low eight switch bits form a sweep step
   assign next_cyl  = {1'b0, q.cyl} + {2'b00, q.inp[7:0]};

   always_comb begin
      if (mode == DTS_MODE_DIRECT) begin
         target = q.inp;
      end else if (mode == DTS_MODE_SEQUENTIAL_FORWARD_MODE && !q.first) begin
         // wrap to cylinder zero in one move past the end
         target = (next_cyl > {1'b0, q.maxcyl}) ? 9'h000 : next_cyl[8:0];
      end else begin
         target = q.cyl;
      end
   end

   always_comb begin
      d = q;
      d.idx_sync   = {q.idx_sync[1:0], index_i};
      d.done_sync  = {q.done_sync[1:0], seek_done_i};
      d.start_prev = start_on;
      if (start_on && !q.start_prev) begin
         d.pending = 1'b1;
         d.first   = 1'b1;
      end
      // register slave: address and data are taken together
      if (wr_hs) begin
         d.awready = 1'b0;
         d.wready  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = `DTS_RESP_OKAY;
         case (waddr)
            `DTS_ADDR_CTRL: begin
               d.ctrl = 8'(wmerge({24'h000000, q.ctrl}, s_axi_wdata_i, s_axi_wstrb_i));
               if (!d.ctrl[`DTS_CTRL_START]) begin
                  d.pending = 1'b0;
               end
            end
            `DTS_ADDR_INPUT: begin
               d.inp = 9'(wmerge({23'h000000, q.inp}, s_axi_wdata_i, s_axi_wstrb_i));
            end
            `DTS_ADDR_MAXCYL: begin
               d.maxcyl = 9'(wmerge({23'h000000, q.maxcyl}, s_axi_wdata_i, s_axi_wstrb_i));
            end
            `DTS_ADDR_LOAD, `DTS_ADDR_RTZ: begin
               d.bresp = `DTS_RESP_OKAY;
            end
            default: begin
               d.bresp = `DTS_RESP_SLVERR;
            end
         endcase
      end else if (!q.awready && !q.bvalid && s_axi_awvalid_i && s_axi_wvalid_i) begin
         d.awready = 1'b1;
         d.wready  = 1'b1;
      end
      if (q.bvalid && s_axi_bready_i) begin
         d.bvalid = 1'b0;
      end
      if (rd_hs) begin
         d.arready = 1'b0;
         d.rvalid  = 1'b1;
         d.rresp   = `DTS_RESP_OKAY;
         case (raddr)
            `DTS_ADDR_CTRL:    d.rdata = {24'h000000, q.ctrl};
            `DTS_ADDR_INPUT:   d.rdata = {23'h000000, q.inp};
            `DTS_ADDR_PATTERN: d.rdata = {20'h00000, q.pattern};
            `DTS_ADDR_STATUS:  d.rdata = {13'h0000, q.wgate, q.rgate, q.state, q.head, q.cyl};
            `DTS_ADDR_MAXCYL:  d.rdata = {23'h000000, q.maxcyl};
            `DTS_ADDR_LOAD, `DTS_ADDR_RTZ: begin
               d.rdata = 32'h00000000;
            end
            default: begin
               d.rdata = 32'h00000000;
               d.rresp = `DTS_RESP_SLVERR;
            end
         endcase
      end else if (!q.arready && !q.rvalid && s_axi_arvalid_i) begin
         d.arready = 1'b1;
      end
      if (q.rvalid && s_axi_rready_i) begin
         d.rvalid = 1'b0;
      end
      // load strobe, steered by the mode selector
      if (load_hs) begin
         case (mode)
            DTS_MODE_UPPER:  d.pattern[11:6] = q.inp[5:0];
            DTS_MODE_LOWER:  d.pattern[5:0]  = q.inp[5:0];
            DTS_MODE_HEAD:   d.head          = q.inp[4:0];
            default:         d.pattern       = q.pattern;
         endcase
      end
      if (q.state == ST_XFER && 32'(q.dly_cnt) < PAT_DLY_CYC) begin
         d.dly_cnt = q.dly_cnt + 16'h0001;
      end
      case (q.state)
         ST_IDLE: begin
            if (rtz_hs && !q.pending) begin
               d.rtz_req = 1'b1;
               d.state   = ST_RTZ;
            end
         end
         ST_RTZ: begin
            if (done_rise) begin
               d.rtz_req = 1'b0;
               d.cyl     = 9'h000;
               d.head    = 5'h00;
               d.state   = ST_IDLE;
            end
         end
         ST_SEEK: begin
            if (done_rise) begin
               d.seek_req = 1'b0;
               d.cyl      = q.seek_cyl;
               d.state    = (op == DTS_OP_ACCESS) ? ST_DONE : ST_WAIT_IDX;
            end
         end
         ST_WAIT_IDX: begin
            if (idx_rise) begin
               d.dly_cnt = 16'h0000;
               d.wgate   = (op == DTS_OP_WRITE);
               d.rgate   = (op == DTS_OP_READ);
               d.state   = ST_XFER;
            end
         end
         ST_XFER: begin
            if (idx_rise) begin
               d.wgate = 1'b0;
               d.rgate = 1'b0;
               d.state = ST_DONE;
            end
         end
         ST_DONE: begin
            d.state = ST_IDLE;
         end
         default: begin
            d.state = ST_IDLE;
         end
      endcase
      if (go_step) begin
         d.pending = 1'b0;
         d.first   = 1'b0;
         if (q.ctrl[`DTS_CTRL_RWONLY]) begin
            d.state = (op == DTS_OP_ACCESS) ? ST_DONE : ST_WAIT_IDX;
         end else begin
            d.seek_req = 1'b1;
            d.seek_cyl = target;
            d.state    = ST_SEEK;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q        <= '0;
         q.maxcyl <= `DTS_MAXCYL_RST;
      end else begin
         q <= d;
      end
   end

   dts_pat_buf u_buf (
      .ref_clk_i   (ref_clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (push),
      .in_data_i   (q.pattern),
      .in_ready_o  (),
      .out_valid_o (wr_data_valid_o),
      .out_data_o  (wr_data_o),
      .out_ready_i (wr_data_ready_i)
   );

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_wgate_rise_idx:
      assert property ($rose(q.wgate) |-> $past(idx_rise) && $past(q.state) == ST_WAIT_IDX)
      else $error("write gate rose without an index edge");
   a_wgate_fall_idx:
      assert property ($fell(q.wgate) |-> $past(idx_rise) && q.state == ST_DONE)
      else $error("write gate dropped away from the ending index");
   a_pattern_delay:
      assert property ($rose(q.wgate) |-> (!push && q.state == ST_XFER)[*8])
      else $error("pattern pushed before the index delay");
   a_seek_first:
      assert property (q.state == ST_SEEK && !done_rise |=> q.state == ST_SEEK && q.seek_req)
      else $error("track operation left the seek before it finished");
   a_load_upper:
      assert property (load_hs && mode == DTS_MODE_UPPER
                       |=> upper_pattern_o == $past(q.inp[5:0]) && $stable(lower_pattern_o))
      else $error("upper pattern half not loaded");
   a_load_lower:
      assert property (load_hs && mode == DTS_MODE_LOWER
                       |=> lower_pattern_o == $past(q.inp[5:0]) && $stable(upper_pattern_o))
      else $error("lower pattern half not loaded");
   a_single_stop:
      assert property (q.state == ST_DONE && !q.ctrl[`DTS_CTRL_REPEAT] |=> q.state == ST_IDLE)
      else $error("single mode started another operation");
   a_repeat_runs:
      assert property (q.state == ST_DONE && q.ctrl[`DTS_CTRL_REPEAT] && start_on
                       |=> q.state != ST_IDLE)
      else $error("repeat mode stopped while start is on");
   a_rw_only_noseek:
      assert property (go_step && q.ctrl[`DTS_CTRL_RWONLY] |=> !seek_req_o && $stable(q.cyl))
      else $error("read/write-only mode issued a seek");
   a_rtz_head_clr:
      assert property (q.state == ST_RTZ && done_rise |=> head_sel_o == 5'h00 && q.cyl == 9'h000)
      else $error("head number not cleared by return to zero");
   a_sweep_wrap:
      assert property ($rose(seek_req_o) && mode == DTS_MODE_SEQUENTIAL_FORWARD_MODE
                       |-> seek_cyl_o <= q.maxcyl
                           && (seek_cyl_o == 9'h000 || seek_cyl_o - q.cyl <= `DTS_SEEK_MAX))
      else $error("sweep step out of range");
endmodule

/* verilog/dts_defs.svh */
// register offsets, field positions, reset values and timing counts of the track sequencer
`ifndef DTS_DEFS_SVH
`define DTS_DEFS_SVH
`define DTS_ADDR_CTRL      8'h00
`define DTS_ADDR_INPUT     8'h04
`define DTS_ADDR_LOAD      8'h08
`define DTS_ADDR_RTZ       8'h0C
`define DTS_ADDR_PATTERN   8'h10
`define DTS_ADDR_STATUS    8'h14
`define DTS_ADDR_MAXCYL    8'h18
`define DTS_CTRL_START     0
`define DTS_CTRL_REPEAT    1
`define DTS_CTRL_RWONLY    2
`define DTS_CTRL_OP_LSB    3
`define DTS_CTRL_MODE_LSB  5
`define DTS_MAXCYL_RST     9'h194
`define DTS_SEEK_MAX       9'h0FF
`define DTS_RESP_OKAY      2'h0
`define DTS_RESP_SLVERR    2'h2
`define DTS_CLK_PERIOD_NS  20
`define DTS_PAT_DLY_US     630
`endif

/* verilog/dts_pkg.sv */
// types of the track sequencer: modes, operations, states and state records
package dts_pkg;
   typedef enum logic [2:0] {
      DTS_MODE_DIRECT  = 3'b000,
      DTS_MODE_SEQUENTIAL_FORWARD_MODE = 3'b001,
      DTS_MODE_UPPER   = 3'b010,
      DTS_MODE_LOWER   = 3'b011,
      DTS_MODE_HEAD    = 3'b100
   } dts_mode_e;

   typedef enum logic [1:0] {
      DTS_OP_ACCESS = 2'b00,
      DTS_OP_READ   = 2'b01,
      DTS_OP_WRITE  = 2'b10
   } dts_op_e;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_RTZ      = 3'b001,
      ST_SEEK     = 3'b010,
      ST_WAIT_IDX = 3'b011,
      ST_XFER     = 3'b100,
      ST_DONE     = 3'b101
   } dts_state_e;

   typedef struct packed {
      logic [11:0] data0;
      logic [11:0] data1;
      logic        v0;
      logic        v1;
   } dts_buf_s;

   typedef struct packed {
      dts_state_e  state;
      logic [2:0]  idx_sync;
      logic [2:0]  done_sync;
      logic        start_prev;
      logic        pending;
      logic        first;
      logic [7:0]  ctrl;
      logic [8:0]  inp;
      logic [8:0]  maxcyl;
      logic [11:0] pattern;
      logic [4:0]  head;
      logic [8:0]  cyl;
      logic [15:0] dly_cnt;
      logic        wgate;
      logic        rgate;
      logic        seek_req;
      logic        rtz_req;
      logic [8:0]  seek_cyl;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } dts_seq_s;
endpackage

/* verilog/dts_pat_buf.sv */
// two-entry pattern word buffer with registered valid and ready on both sides
`timescale 1ns/10ps
module dts_pat_buf
   import dts_pkg::*;
(
   input  wire logic        ref_clk_i,   // tester clock
   input  wire logic        rst_n_i,     // async reset, active low
   input  wire logic        in_valid_i,  // word offered
   input  wire logic [11:0] in_data_i,   // offered word
   output logic             in_ready_o,  // room for a word
   output logic             out_valid_o, // word held at head
   output logic [11:0]      out_data_o,  // head word
   input  wire logic        out_ready_i  // drain side takes head
);
   dts_buf_s q;
   dts_buf_s d;
   logic     push;
   logic     pop;

   // both outputs sit straight on flops, so the second entry absorbs a stall
   assign in_ready_o  = ~q.v1;
   assign out_valid_o = q.v0;
   assign out_data_o  = q.data0;
   assign push        = in_valid_i & ~q.v1;
   assign pop         = q.v0 & out_ready_i;

   always_comb begin
      d = q;
      if (pop) begin
         if (q.v1) begin
            d.data0 = q.data1;
            d.v1    = 1'b0;
         end else begin
            d.data0 = in_data_i;
            d.v0    = push;
         end
      end else if (push) begin
         if (!q.v0) begin
            d.data0 = in_data_i;
            d.v0    = 1'b1;
         end else begin
            d.data1 = in_data_i;
            d.v1    = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule

/* test/dts_drive_model.sv */
// disk drive model: index pulses, seek completion and a stalling write channel
`timescale 1ns/10ps
module dts_drive_model #(
   parameter int IDX_PER  = 60, // cycles per revolution
   parameter int SEEK_DLY = 7   // arm travel time in cycles
)(
   input  wire logic ref_clk_i,   // tester clock
   input  wire logic rst_n_i,     // async reset, active low
   input  wire logic seek_req_i,  // seek request level
   input  wire logic rtz_i,       // return-to-zero request level
   input  wire logic wr_valid_i,  // pattern word offered
   output logic      index_o,     // index pulse
   output logic      seek_done_o, // seek complete
   output logic      wr_ready_o   // write channel takes word
);
   int rev_cnt;
   int mv_cnt;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rev_cnt     <= 0;
         mv_cnt      <= 0;
         index_o     <= 1'h0;
         seek_done_o <= 1'h0;
         wr_ready_o  <= 1'h0;
      end else begin
         rev_cnt    <= (rev_cnt == IDX_PER - 1) ? 0 : rev_cnt + 1;
         // three cycles wide so the three-stage sync never misses it
         index_o    <= (rev_cnt < 3);
         // stalls half of each four cycles to exercise the buffer
         wr_ready_o <= rev_cnt[1] & wr_valid_i;
         if (seek_req_i || rtz_i) begin
            mv_cnt      <= mv_cnt + 1;
            seek_done_o <= (mv_cnt >= SEEK_DLY);
         end else begin
            mv_cnt      <= 0;
            seek_done_o <= 1'h0;
         end
      end
   end
endmodule

/* test/dts_track_seq_test.sv */
// self-checking bench of the track sequencer: register bus, pattern load, sweeps
`timescale 1ns/10ps
`include "dts_defs.svh"
module dts_track_seq_test import dts_pkg::*;;
   localparam int PAT = 20;
   localparam int IDX = 60;
   localparam logic [11:0] PATW = {6'h2A, 6'h15};
   logic        ref_clk_i, rst_n_i;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic        index_i, seek_done_i, seek_req_o, rtz_o, write_gate_o, read_gate_o;
   logic [8:0]  seek_cyl_o;
   logic [4:0]  head_sel_o;
   logic [11:0] wr_data_o;
   logic        wr_data_valid_o, wr_data_ready_i, idx_q, wg_q, sk_q;
   logic [5:0]  upper_o, lower_o;
   int          bad_count, n_checks, idx_in_gate, seeks;

   dts_track_seq #(.PAT_DLY_CYC(PAT)) u_dts_track_seq (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .index_i(index_i),
      .seek_done_i(seek_done_i), .seek_req_o(seek_req_o), .seek_cyl_o(seek_cyl_o),
      .return_to_zero_seek_o(rtz_o), .head_sel_o(head_sel_o),
      .write_gate_o(write_gate_o), .read_gate_o(read_gate_o), .wr_data_o(wr_data_o),
      .wr_data_valid_o(wr_data_valid_o), .wr_data_ready_i(wr_data_ready_i),
      .upper_pattern_o(upper_o), .lower_pattern_o(lower_o));

   dts_drive_model #(.IDX_PER(IDX)) u_dts_drive_model (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .seek_req_i(seek_req_o), .rtz_i(rtz_o),
      .wr_valid_i(wr_data_valid_o), .index_o(index_i), .seek_done_o(seek_done_i),
      .wr_ready_o(wr_data_ready_i));

   initial begin
      ref_clk_i = 1'h0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end

   // index edges seen inside a write window, and seek starts
   always @(posedge ref_clk_i) begin
      idx_q <= index_i;
      wg_q  <= write_gate_o;
      sk_q  <= seek_req_o;
      if (write_gate_o && !wg_q)
         idx_in_gate = 0;
      if (index_i && !idx_q && write_gate_o)
         idx_in_gate++;
      if (seek_req_o && !sk_q)
         seeks++;
   end

   task conclude();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %0t got %h want %h", $time, got, exp);
      end
   endtask

   function automatic logic sig(input int s);
      case (s)
         0: sig = seek_req_o;
         1: sig = write_gate_o;
         2: sig = read_gate_o;
         3: sig = wr_data_valid_o;
         default: sig = rtz_o;
      endcase
   endfunction

   task wait_sig(input int s, input logic lv, input int lim, output int n);
      n = 0;
      while (sig(s) !== lv && n < lim) begin
         @(posedge ref_clk_i);
         n++;
      end
      if (n >= lim) begin
         bad_count++;
         $display("unexpected %0t wait timed out", $time);
      end
   endtask

   task quiet(input int s, input int lim);
      logic hit;
      hit = 1'h0;
      repeat (lim) begin
         @(posedge ref_clk_i);
         if (sig(s) !== 1'h0)
            hit = 1'h1;
      end
      chk(32'(hit), 32'h0);
   endtask

   task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      do begin
         @(posedge ref_clk_i);
         if (awready)
            awvalid <= 1'h0;
         if (wready)
            wvalid <= 1'h0;
         n++;
      end while (bvalid !== 1'h1 && n < 50);
      bready <= 1'h0;
      chk(32'(bvalid), 32'h1);
      chk(32'(bresp), 32'(er));
   endtask

   task axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      do begin
         @(posedge ref_clk_i);
         if (arready)
            arvalid <= 1'h0;
         n++;
      end while (rvalid !== 1'h1 && n < 50);
      rready <= 1'h0;
      chk(32'(rvalid), 32'h1);
      chk(rdata, ed);
      chk(32'(rresp), 32'(er));
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      axi_wr(a, d, `DTS_RESP_OKAY);
   endtask

   function automatic logic [31:0] ctl(input logic s, r, w, input dts_op_e op,
                                       input dts_mode_e m);
      ctl = {24'h0, m, op, w, r, s};
   endfunction

   task t_regs();
      axi_rd(`DTS_ADDR_MAXCYL, 32'h194, `DTS_RESP_OKAY);
      axi_rd(8'h1C, 32'h0, `DTS_RESP_SLVERR);
      axi_wr(8'h1C, 32'hFFFFFFFF, `DTS_RESP_SLVERR);
      axi_rd(`DTS_ADDR_LOAD, 32'h0, `DTS_RESP_OKAY);
      $display("t_regs done");
   endtask

   task t_pattern();
      wr(`DTS_ADDR_CTRL, ctl(1'h0, 1'h0, 1'h0, DTS_OP_ACCESS, DTS_MODE_UPPER));
      wr(`DTS_ADDR_INPUT, 32'h1EA);
      wr(`DTS_ADDR_LOAD, 32'h0);
      wr(`DTS_ADDR_CTRL, ctl(1'h0, 1'h0, 1'h0, DTS_OP_ACCESS, DTS_MODE_LOWER));
      wr(`DTS_ADDR_INPUT, 32'h1D5);
      wr(`DTS_ADDR_LOAD, 32'h0);
      axi_rd(`DTS_ADDR_PATTERN, 32'(PATW), `DTS_RESP_OKAY);
      chk(32'(upper_o), 32'h2A);
      chk(32'(lower_o), 32'h15);
      $display("t_pattern done");
   endtask

   task t_head();
      int n;
      wr(`DTS_ADDR_CTRL, ctl(1'h0, 1'h0, 1'h0, DTS_OP_ACCESS, DTS_MODE_HEAD));
      wr(`DTS_ADDR_INPUT, 32'h1F5);
      wr(`DTS_ADDR_LOAD, 32'h0);
      chk(32'(head_sel_o), 32'h15);
      wr(`DTS_ADDR_RTZ, 32'h0);
      wait_sig(4, 1'h1, 20, n);
      wait_sig(4, 1'h0, 100, n);
      chk(32'(head_sel_o), 32'h0);
      $display("t_head done");
   endtask

   task t_single();
      int n;
      wr(`DTS_ADDR_INPUT, 32'h3);
      wr(`DTS_ADDR_CTRL, ctl(1'h1, 1'h0, 1'h0, DTS_OP_WRITE, DTS_MODE_DIRECT));
      wait_sig(0, 1'h1, 50, n);
      chk(32'(seek_cyl_o), 32'h3);
      chk(32'(write_gate_o), 32'h0);
      wait_sig(1, 1'h1, 300, n);
      wait_sig(3, 1'h1, 200, n);
      chk(32'(n), 32'(PAT + 1));
      chk(32'(wr_data_o), 32'(PATW));
      wait_sig(1, 1'h0, 200, n);
      chk(32'(idx_in_gate), 32'h1);
      quiet(1, 3 * IDX);
      wr(`DTS_ADDR_CTRL, ctl(1'h0, 1'h0, 1'h0, DTS_OP_WRITE, DTS_MODE_DIRECT));
      wr(`DTS_ADDR_CTRL, ctl(1'h1, 1'h0, 1'h0, DTS_OP_WRITE, DTS_MODE_DIRECT));
      wait_sig(1, 1'h1, 300, n);
      wait_sig(1, 1'h0, 200, n);
      chk(32'(idx_in_gate), 32'h1);
      $display("t_single done");
   endtask

   task t_rwonly();
      int n;
      int s0;
      wr(`DTS_ADDR_CTRL, ctl(1'h0, 1'h0, 1'h0, DTS_OP_ACCESS, DTS_MODE_HEAD));
      wr(`DTS_ADDR_INPUT, 32'h9);
      wr(`DTS_ADDR_LOAD, 32'h0);
      wr(`DTS_ADDR_INPUT, 32'h7);
      s0 = seeks;
      wr(`DTS_ADDR_CTRL, ctl(1'h1, 1'h0, 1'h1, DTS_OP_WRITE, DTS_MODE_DIRECT));
      wait_sig(1, 1'h1, 300, n);
      chk(32'(seeks), 32'(s0));
      chk(32'(head_sel_o), 32'h9);
      wait_sig(1, 1'h0, 200, n);
      wr(`DTS_ADDR_CTRL, 32'h0);
      $display("t_rwonly done");
   endtask

   task seq_run(input dts_op_e op, input logic [8:0] st, mx, e0, e1, e2);
      logic [8:0] ex [3];
      int n;
      ex = '{e0, e1, e2};
      wr(`DTS_ADDR_RTZ, 32'h0);
      wait_sig(4, 1'h1, 20, n);
      wait_sig(4, 1'h0, 100, n);
      wr(`DTS_ADDR_MAXCYL, 32'(mx));
      wr(`DTS_ADDR_INPUT, 32'(st));
      wr(`DTS_ADDR_CTRL, ctl(1'h1, 1'h1, 1'h0, op, DTS_MODE_SEQUENTIAL_FORWARD_MODE));
      for (int i = 0; i < 3; i++) begin
         wait_sig(0, 1'h1, 400, n);
         chk(32'(seek_cyl_o), 32'(ex[i]));
         chk(32'(head_sel_o), 32'h0);
         chk(32'(write_gate_o), 32'h0);
         wait_sig(0, 1'h0, 100, n);
         if (op != DTS_OP_ACCESS)
            wait_sig((op == DTS_OP_READ) ? 2 : 1, 1'h1, 200, n);
      end
      wr(`DTS_ADDR_CTRL, 32'h0);
      wait_sig(0, 1'h0, 100, n);
      quiet(0, 3 * IDX);
      wait_sig(1, 1'h0, 200, n);
      wait_sig(2, 1'h0, 200, n);
      $display("seq_run done");
   endtask

   initial begin
      rst_n_i = 1'h0;
      {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
      wstrb = 4'hF;
      bad_count = 0;
      n_checks = 0;
      idx_in_gate = 0;
      seeks = 0;
      repeat (2) @(posedge ref_clk_i);
      rst_n_i <= 1'h1;
      t_regs();
      t_pattern();
      t_head();
      t_single();
      t_rwonly();
      seq_run(DTS_OP_WRITE, 9'h1, 9'h1, 9'h0, 9'h1, 9'h0);
      seq_run(DTS_OP_READ, 9'h1, 9'h194, 9'h0, 9'h1, 9'h2);
      seq_run(DTS_OP_ACCESS, 9'h1FF, 9'h194, 9'h0, 9'hFF, 9'h0);
      conclude();
   end

   // the whole sequence needs well under ten thousand cycles
   initial begin
      #(20 * 20000);
      bad_count++;
      $display("unexpected %0t watchdog expired", $time);
      conclude();
   end
endmodule
